/* design/int_sig_pkg.sv */
package int_sig_pkg;
  // ---------------------------------------------------------------
  // sizes, fixed ids and idle priority
  // ---------------------------------------------------------------
  localparam int NUM_SPI = 8;
  localparam int ID_W = 10;
  localparam int PRIO_W = 8;
  localparam logic [ID_W-1:0] SPI_BASE_ID = 10'h020;
  localparam logic [ID_W-1:0] SPURIOUS_ID = 10'h3FF;
  localparam logic [PRIO_W-1:0] IDLE_PRIO = 8'hFF;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PH_LAT_CYC = 12;
  localparam int PH_LAT_MIN_CYC = 10;
  localparam int PH_LAT_MAX_CYC = 20;
  localparam int SEARCH_CYC = 4;
  localparam int ACK_DROP_CYC = 3;
  localparam int PEND_CLR_CYC = 2;
  localparam int VIRT_LAT_CYC = 2;
  localparam logic [4:0] PH_LAT_CNT = 5'(PH_LAT_CYC - SEARCH_CYC - 1);
  localparam logic [1:0] ACK_DROP_CNT = 2'(ACK_DROP_CYC - 2);
  localparam logic [1:0] VIRT_LAT_CNT = 2'(VIRT_LAT_CYC - 2);
  // ---------------------------------------------------------------
  // control bit positions and reset value
  // ---------------------------------------------------------------
  localparam int CTRL_FIQ_EN_BIT = 0;
  localparam int CTRL_SPLIT_EOI_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CPU_IDLE = 4'h1,
    CPU_WAIT = 4'h2,
    CPU_SIGNAL = 4'h4,
    CPU_DROP = 4'h8
  } cpu_state_t;
endpackage

/* design/interrupt_signaling_sequencer.sv */
module interrupt_signaling_sequencer
  import int_sig_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [NUM_SPI-1:0] SHARED_IRQ_INPUTS,
  input wire logic [NUM_SPI-1:0] SPI_GROUP1,
  input wire logic [NUM_SPI-1:0] SPI_ENABLE,
  input wire logic [NUM_SPI*PRIO_W-1:0] SPI_PRIORITY,
  input wire logic [1:0] CPU_IF_CONTROL,
  input wire logic INT_ACK_READ,
  output logic [ID_W-1:0] INT_ACK_REG,
  input wire logic END_OF_INT_WRITE,
  input wire logic [ID_W-1:0] END_OF_INT_REG,
  input wire logic LIST_ENTRY_WRITE,
  input wire logic [ID_W-1:0] LIST_VIRT_ID,
  input wire logic [ID_W-1:0] PHYS_ID_FIELD,
  input wire logic LIST_HW,
  input wire logic VM_INT_ACK_READ,
  output logic [ID_W-1:0] VM_INT_ACK_REG,
  input wire logic VM_END_OF_INT_WRITE,
  input wire logic [ID_W-1:0] VM_END_OF_INT_REG,
  output logic [NUM_SPI-1:0] PENDING,
  output logic [NUM_SPI-1:0] ACTIVE,
  output logic LIST_ENTRY_FULL,
  output logic CPU_FAST_INT_N,
  output logic CPU_NORM_INT_N,
  output logic VIRT_FAST_INT_N
);
  // ---------------------------------------------------------------
  // detection and pending state
  // ---------------------------------------------------------------
  logic [NUM_SPI-1:0] detect;
  logic [NUM_SPI-1:0] low_seen;
  logic [NUM_SPI-1:0] pending;
  logic [NUM_SPI-1:0] active;
  logic [NUM_SPI-1:0] ack_onehot;
  logic [NUM_SPI-1:0] eoi_onehot;
  logic [NUM_SPI-1:0] veoi_onehot;
  logic ack_take;
  logic phys_eoi;
  logic hw_deact;
  logic [ID_W-1:0] phys_id_held;
  wire split_eoi = CPU_IF_CONTROL[CTRL_SPLIT_EOI_BIT];
  wire fiq_en = CPU_IF_CONTROL[CTRL_FIQ_EN_BIT];
  wire [ID_W-1:0] eoi_off = END_OF_INT_REG - SPI_BASE_ID;
  wire eoi_hit = END_OF_INT_WRITE && END_OF_INT_REG >= SPI_BASE_ID
    && eoi_off < ID_W'(NUM_SPI);
  assign phys_eoi = eoi_hit && !split_eoi;
  // ---------------------------------------------------------------
  // pending and active update
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      detect <= '0;
      low_seen <= '0;
      pending <= '0;
      active <= '0;
    end else begin
      detect <= SHARED_IRQ_INPUTS;
      low_seen <= ~detect;
      pending <= (pending | detect) & ~(low_seen & ~detect);
      active <= (active & ~eoi_onehot & ~veoi_onehot) | ack_onehot;
    end
  end
  assign PENDING = pending;
  assign ACTIVE = active;
  genvar g;
  generate
    for (g = 0; g < NUM_SPI; g++) begin : g_dec
      assign ack_onehot[g] = ack_take && INT_ACK_REG == SPI_BASE_ID + ID_W'(g);
      assign eoi_onehot[g] = phys_eoi && eoi_off == ID_W'(g);
      assign veoi_onehot[g] = hw_deact && phys_id_held == SPI_BASE_ID + ID_W'(g);
    end
  endgenerate
  // ---------------------------------------------------------------
  // priority search
  // ---------------------------------------------------------------
  prio_if pbus();
  logic running_valid;
  logic [PRIO_W-1:0] running_prio;
  logic search_go;
  assign pbus.cand = pending & ~active & SPI_ENABLE;
  assign pbus.prio = SPI_PRIORITY;
  assign pbus.start = search_go;
  prio_search u_search (
    .clk(REF_CLK),
    .rst(RESET),
    .bus(pbus)
  );
  wire beats_running = !running_valid || pbus.best_prio < running_prio;
  wire [2:0] best_idx = 3'(pbus.best_id - SPI_BASE_ID);
  wire best_grp1 = SPI_GROUP1[best_idx];
  // ---------------------------------------------------------------
  // cpu interface state machine
  // ---------------------------------------------------------------
  cpu_state_t state;
  cpu_state_t next_state;
  logic [4:0] lat_cnt;
  logic [1:0] drop_cnt;
  logic sel_grp1;
  logic fast_on;
  logic norm_on;
  logic [ID_W-1:0] sel_id;
  assign ack_take = INT_ACK_READ && state == CPU_SIGNAL;
  assign search_go = 1'b1;
  always_comb begin
    next_state = state;
    case (state)
      CPU_IDLE: begin
        if (pbus.done && pbus.found && beats_running) begin
          next_state = CPU_WAIT;
        end
      end
      CPU_WAIT: begin
        if (lat_cnt == 5'h00) begin
          next_state = CPU_SIGNAL;
        end
      end
      CPU_SIGNAL: begin
        if (INT_ACK_READ) begin
          next_state = CPU_DROP;
        end
      end
      CPU_DROP: begin
        if (drop_cnt == 2'h0) begin
          next_state = CPU_IDLE;
        end
      end
      default: next_state = CPU_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state <= CPU_IDLE;
      lat_cnt <= 5'h00;
      drop_cnt <= 2'h0;
      sel_id <= SPURIOUS_ID;
      sel_grp1 <= 1'b0;
      INT_ACK_REG <= SPURIOUS_ID;
      running_valid <= 1'b0;
      running_prio <= IDLE_PRIO;
    end else begin
      state <= next_state;
      if (state == CPU_IDLE && next_state == CPU_WAIT) begin
        lat_cnt <= PH_LAT_CNT;
        sel_id <= pbus.best_id;
        sel_grp1 <= best_grp1;
      end else if (state == CPU_WAIT && lat_cnt != 5'h00) begin
        lat_cnt <= lat_cnt - 5'h01;
      end
      if (state == CPU_WAIT && next_state == CPU_SIGNAL) begin
        INT_ACK_REG <= sel_id;
      end
      if (state == CPU_SIGNAL && pbus.done && pbus.found && beats_running
          && pbus.best_id != INT_ACK_REG) begin
        INT_ACK_REG <= pbus.best_id;
        sel_grp1 <= best_grp1;
      end
      if (ack_take) begin
        drop_cnt <= ACK_DROP_CNT;
        running_valid <= 1'b1;
        running_prio <= SPI_PRIORITY[3'(INT_ACK_REG - SPI_BASE_ID)*PRIO_W +: PRIO_W];
      end else if (state == CPU_DROP && drop_cnt != 2'h0) begin
        drop_cnt <= drop_cnt - 2'h1;
      end
      if (eoi_hit) begin
        running_valid <= 1'b0;
        running_prio <= IDLE_PRIO;
      end
    end
  end
  assign fast_on = (state == CPU_SIGNAL || state == CPU_DROP) && !sel_grp1 && fiq_en;
  assign norm_on = (state == CPU_SIGNAL || state == CPU_DROP) && (sel_grp1 || !fiq_en);
  // ---------------------------------------------------------------
  // virtual interface
  // ---------------------------------------------------------------
  logic list_full;
  logic list_pend;
  logic list_act;
  logic list_hw;
  logic [ID_W-1:0] list_vid;
  logic [1:0] vlat;
  logic vout;
  logic vdrop;
  wire vm_ack = VM_INT_ACK_READ && list_pend && vout;
  wire vm_eoi = VM_END_OF_INT_WRITE && list_act && VM_END_OF_INT_REG == list_vid;
  assign hw_deact = vm_eoi && list_hw;
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      list_full <= 1'b0;
      list_pend <= 1'b0;
      list_act <= 1'b0;
      list_hw <= 1'b0;
      list_vid <= SPURIOUS_ID;
      phys_id_held <= SPURIOUS_ID;
      vlat <= 2'h0;
      vout <= 1'b0;
      vdrop <= 1'b0;
      VM_INT_ACK_REG <= SPURIOUS_ID;
    end else begin
      if (LIST_ENTRY_WRITE && !list_full) begin
        list_full <= 1'b1;
        list_pend <= 1'b1;
        list_hw <= LIST_HW;
        list_vid <= LIST_VIRT_ID;
        phys_id_held <= PHYS_ID_FIELD;
        vlat <= VIRT_LAT_CNT;
      end else if (list_pend && !vout && !vdrop) begin
        if (vlat == 2'h0) begin
          vout <= 1'b1;
          VM_INT_ACK_REG <= list_vid;
        end else begin
          vlat <= vlat - 2'h1;
        end
      end
      if (vm_ack) begin
        list_pend <= 1'b0;
        list_act <= 1'b1;
        vdrop <= 1'b1;
        vlat <= VIRT_LAT_CNT;
      end else if (vdrop) begin
        if (vlat == 2'h0) begin
          vout <= 1'b0;
          vdrop <= 1'b0;
        end else begin
          vlat <= vlat - 2'h1;
        end
      end
      if (vm_eoi) begin
        list_act <= 1'b0;
        list_full <= 1'b0;
      end
    end
  end
  assign LIST_ENTRY_FULL = list_full;
  // ---------------------------------------------------------------
  // active-low outputs
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      CPU_FAST_INT_N <= 1'b1;
      CPU_NORM_INT_N <= 1'b1;
      VIRT_FAST_INT_N <= 1'b1;
    end else begin
      CPU_FAST_INT_N <= !fast_on;
      CPU_NORM_INT_N <= !norm_on;
      VIRT_FAST_INT_N <= !vout;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_idle_high;
    @(posedge REF_CLK) disable iff (RESET)
      state == CPU_IDLE |=> CPU_FAST_INT_N && CPU_NORM_INT_N;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("output low while idle");
  property p_drop3;
    @(posedge REF_CLK) disable iff (RESET)
      ack_take |-> ##3 (state == CPU_IDLE) ##1 (CPU_FAST_INT_N && CPU_NORM_INT_N);
  endproperty
  a_drop3: assert property (p_drop3) else $error("output not dropped after ack");
  sequence s_wait_start;
    state == CPU_IDLE ##1 state == CPU_WAIT;
  endsequence
  property p_latency;
    @(posedge REF_CLK) disable iff (RESET)
      s_wait_start |-> ##[1:20] state == CPU_SIGNAL;
  endproperty
  a_latency: assert property (p_latency) else $error("latency out of range");
  property p_no_glitch;
    @(posedge REF_CLK) disable iff (RESET)
      state == CPU_SIGNAL && !INT_ACK_READ |=> state == CPU_SIGNAL;
  endproperty
  a_no_glitch: assert property (p_no_glitch) else $error("signal glitched");
  property p_vhold;
    @(posedge REF_CLK) disable iff (RESET)
      vout && !vm_ack && !vdrop |=> vout;
  endproperty
  a_vhold: assert property (p_vhold) else $error("virtual output lost");
  property p_vassert;
    @(posedge REF_CLK) disable iff (RESET)
      LIST_ENTRY_WRITE && !list_full |-> ##3 !VIRT_FAST_INT_N;
  endproperty
  a_vassert: assert property (p_vassert) else $error("virtual output late");
  property p_split;
    @(posedge REF_CLK) disable iff (RESET)
      eoi_hit && split_eoi && active[eoi_off[2:0]] |=> active[$past(eoi_off[2:0])];
  endproperty
  a_split: assert property (p_split) else $error("split eoi changed state");
  property p_pend;
    @(posedge REF_CLK) disable iff (RESET)
      SHARED_IRQ_INPUTS[0] |-> ##2 pending[0];
  endproperty
  a_pend: assert property (p_pend) else $error("input not made pending");
  property p_ack_active;
    @(posedge REF_CLK) disable iff (RESET)
      ack_take |=> (active & $past(ack_onehot)) == $past(ack_onehot);
  endproperty
  a_ack_active: assert property (p_ack_active) else $error("ack did not set active");
  property p_fast_route;
    @(posedge REF_CLK) disable iff (RESET)
      state == CPU_SIGNAL && !sel_grp1 && fiq_en |=> !CPU_FAST_INT_N && CPU_NORM_INT_N;
  endproperty
  a_fast_route: assert property (p_fast_route) else $error("fast line not used");
  property p_norm_route;
    @(posedge REF_CLK) disable iff (RESET)
      state == CPU_SIGNAL && (sel_grp1 || !fiq_en) |=> !CPU_NORM_INT_N && CPU_FAST_INT_N;
  endproperty
  a_norm_route: assert property (p_norm_route) else $error("normal line not used");
  sequence s_line_drop;
    $fell(detect[0]) ##1 !detect[0];
  endsequence
  property p_pend_clear;
    @(posedge REF_CLK) disable iff (RESET)
      s_line_drop |-> ##1 !pending[0];
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending not removed");
  property p_eoi_clear;
    @(posedge REF_CLK) disable iff (RESET)
      phys_eoi && !ack_take |=> !active[$past(eoi_off[2:0])];
  endproperty
  a_eoi_clear: assert property (p_eoi_clear) else $error("eoi did not deactivate");
  property p_vdrop;
    @(posedge REF_CLK) disable iff (RESET)
      vm_ack |-> ##3 VIRT_FAST_INT_N;
  endproperty
  a_vdrop: assert property (p_vdrop) else $error("virtual output not dropped");
endmodule

/* design/prio_if.sv */
interface prio_if;
  import int_sig_pkg::*;
  logic [NUM_SPI-1:0] cand;
  logic [NUM_SPI*PRIO_W-1:0] prio;
  logic start;
  logic done;
  logic found;
  logic [ID_W-1:0] best_id;
  logic [PRIO_W-1:0] best_prio;
  modport ctl(output cand, prio, start, input done, found, best_id, best_prio);
  modport srch(input cand, prio, start, output done, found, best_id, best_prio);
endinterface

/* design/prio_search.sv */
module prio_search
  import int_sig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  prio_if.srch bus
);
  // ---------------------------------------------------------------
  // snapshot taken at start, scanned over several cycles
  // ---------------------------------------------------------------
  logic [NUM_SPI-1:0] snap;
  logic [2:0] idx;
  logic busy;
  logic [2:0] step;
  logic found;
  logic [ID_W-1:0] best_id;
  logic [PRIO_W-1:0] best_prio;
  logic done;
  wire [PRIO_W-1:0] p0 = bus.prio[idx*PRIO_W +: PRIO_W];
  wire [PRIO_W-1:0] p1 = bus.prio[(idx+3'h1)*PRIO_W +: PRIO_W];
  wire hit0 = snap[idx] && (!found || p0 < best_prio);
  wire [PRIO_W-1:0] mid_prio = hit0 ? p0 : best_prio;
  wire hit1 = snap[idx+3'h1] && (!(found || hit0) || p1 < mid_prio);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap <= '0;
      idx <= 3'h0;
      busy <= 1'b0;
      step <= 3'h0;
      found <= 1'b0;
      best_id <= SPURIOUS_ID;
      best_prio <= IDLE_PRIO;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (bus.start && !busy) begin
        snap <= bus.cand;
        idx <= 3'h0;
        step <= 3'h0;
        busy <= 1'b1;
        found <= 1'b0;
        best_prio <= IDLE_PRIO;
        best_id <= SPURIOUS_ID;
      end else if (busy) begin
        if (hit1) begin
          best_id <= SPI_BASE_ID + ID_W'(idx) + 10'h001;
          best_prio <= p1;
          found <= 1'b1;
        end else if (hit0) begin
          best_id <= SPI_BASE_ID + ID_W'(idx);
          best_prio <= p0;
          found <= 1'b1;
        end
        idx <= idx + 3'h2;
        step <= step + 3'h1;
        if (step == 3'(SEARCH_CYC - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
  assign bus.done = done;
  assign bus.found = found;
  assign bus.best_id = best_id;
  assign bus.best_prio = best_prio;
endmodule

/* test/cpu_core_model.sv */
module cpu_core_model
  import int_sig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fast_n,
  input wire logic norm_n,
  input wire logic [ID_W-1:0] ack_id,
  input wire logic [7:0] ack_gap,
  input wire logic [7:0] svc_gap,
  output logic ack_rd,
  output logic eoi_wr,
  output logic [ID_W-1:0] eoi_id
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // core: acknowledge after ack_gap, end of service after svc_gap
  // ---------------------------------------------------------------
  logic [ID_W-1:0] held = 10'h000;
  initial begin
    ack_rd = 1'b0;
    eoi_wr = 1'b0;
    eoi_id = ~held;
    forever begin
      @(posedge clk);
      if (!rst && (!fast_n || !norm_n)) begin
        repeat (ack_gap) @(posedge clk);
        #1;
        held = ack_id;
        ack_rd = 1'b1;
        @(posedge clk);
        #1;
        ack_rd = 1'b0;
        repeat (svc_gap) @(posedge clk);
        #1;
        eoi_id = held;
        eoi_wr = 1'b1;
        @(posedge clk);
        #1;
        eoi_wr = 1'b0;
        eoi_id = ~held;
      end
    end
  end
endmodule

/* test/interrupt_signaling_sequencer_tb.sv */
module interrupt_signaling_sequencer_tb
  import int_sig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [ID_W-1:0] id; logic fast;} note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_SPI-1:0] irq = 8'h00;
  logic [NUM_SPI-1:0] grp1 = 8'h00;
  logic [NUM_SPI-1:0] en = 8'hFF;
  logic [NUM_SPI*PRIO_W-1:0] prio = 64'h0;
  logic [1:0] ctrl = CTRL_RESET;
  logic lw = 1'b0;
  logic lhw = 1'b1;
  logic [ID_W-1:0] lv_id = 10'h000;
  logic [ID_W-1:0] lp_id = 10'h000;
  logic vack = 1'b0;
  logic veoi = 1'b0;
  logic [ID_W-1:0] veoi_id = 10'h3FF;
  logic [7:0] ack_gap = 8'h02;
  logic [7:0] svc_gap = 8'h1E;
  logic ack_rd;
  logic eoi_wr;
  logic full;
  logic fiq_n;
  logic irq_n;
  logic vfiq_n;
  logic [ID_W-1:0] eoi_id;
  logic [ID_W-1:0] ack_id;
  logic [ID_W-1:0] vack_id;
  logic [NUM_SPI-1:0] pend;
  logic [NUM_SPI-1:0] act;
  int bad_count = 0;
  int total_checks = 0;
  integer seed = 32'h1ad0b280;
  note_t exp_q[$];
  note_t cur;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  interrupt_signaling_sequencer interrupt_signaling_sequencer_i (.REF_CLK(clk), .RESET(rst),
    .SHARED_IRQ_INPUTS(irq), .SPI_GROUP1(grp1), .SPI_ENABLE(en), .SPI_PRIORITY(prio),
    .CPU_IF_CONTROL(ctrl), .INT_ACK_READ(ack_rd), .INT_ACK_REG(ack_id),
    .END_OF_INT_WRITE(eoi_wr), .END_OF_INT_REG(eoi_id), .LIST_ENTRY_WRITE(lw),
    .LIST_VIRT_ID(lv_id), .PHYS_ID_FIELD(lp_id), .LIST_HW(lhw), .VM_INT_ACK_READ(vack),
    .VM_INT_ACK_REG(vack_id), .VM_END_OF_INT_WRITE(veoi), .VM_END_OF_INT_REG(veoi_id),
    .PENDING(pend), .ACTIVE(act), .LIST_ENTRY_FULL(full), .CPU_FAST_INT_N(fiq_n),
    .CPU_NORM_INT_N(irq_n), .VIRT_FAST_INT_N(vfiq_n));
  cpu_core_model cpu_core_model_i (.clk(clk), .rst(rst), .fast_n(fiq_n), .norm_n(irq_n),
    .ack_id(ack_id), .ack_gap(ack_gap), .svc_gap(svc_gap), .ack_rd(ack_rd), .eoi_wr(eoi_wr),
    .eoi_id(eoi_id));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic cond(input int w, input int k);
    case (w)
      0: return pend[k];
      1: return !(fiq_n && irq_n);
      2: return ack_rd;
      default: return eoi_wr;
    endcase
  endfunction
  task automatic wait_for(input int w, input int k, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cond(w, k) !== 1'b1 && n < 300);
    check(16'(n < 300), 16'h1, "wait limit");
    #1;
  endtask
  // each acknowledge takes the oldest note
  always @(negedge clk) begin
    if (ack_rd === 1'b1) begin
      if (exp_q.size() == 0) check(16'h1, 16'h0, "unexpected acknowledge");
      else begin
        cur = exp_q.pop_front();
        check(16'(ack_id), 16'(cur.id), "acknowledged id");
        check(16'({fiq_n, irq_n}), cur.fast ? 16'h1 : 16'h2, "output line");
      end
    end
  end
  task automatic serve(input int k, input logic g1, input logic fen, input logic split);
    int n;
    logic [ID_W-1:0] id;
    id = SPI_BASE_ID + ID_W'(k);
    grp1[k] = g1;
    ctrl = {split, fen};
    prio[k*PRIO_W +: PRIO_W] = 8'($random(seed)) & 8'hFE;
    exp_q.push_back(note_t'{id, !g1 && fen});
    irq[k] = 1'b1;
    wait_for(0, k, n);
    check(16'(n <= 4), 16'h1, "pending delay");
    wait_for(1, k, n);
    check(16'(n >= PH_LAT_MIN_CYC && n <= PH_LAT_MAX_CYC + 1), 16'h1, "latency");
    wait_for(2, k, n);
    tick(2);
    check(16'({fiq_n, irq_n}), (g1 || !fen) ? 16'h2 : 16'h1, "held after ack");
    tick(1);
    check(16'({fiq_n, irq_n}), 16'h3, "dropped after ack");
    check(16'({pend[k], act[k]}), 16'h3, "active and pending");
    irq[k] = 1'b0;
    tick(4);
    check(16'({pend[k], act[k]}), 16'h1, "pending removed");
    wait_for(3, k, n);
    tick(3);
    check(16'(act[k]), 16'(split), "end of interrupt");
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    int m;
    int n;
    int highs;
    tick(4);
    rst = 1'b0;
    tick(1);
    check(16'({fiq_n, irq_n, vfiq_n}), 16'h7, "idle outputs");
    check(16'(ack_id), 16'(SPURIOUS_ID), "idle id");
    for (int i = 0; i < 4; i++) begin
      serve($unsigned($random(seed)) % NUM_SPI, i[0], i[1], 1'b0);
    end
    $display("test routing done");
    ack_gap = 8'h50;
    k = $unsigned($random(seed)) % NUM_SPI;
    m = (k + 1) % NUM_SPI;
    grp1 = 8'h00;
    ctrl = 2'h1;
    prio[k*PRIO_W +: PRIO_W] = 8'h80;
    prio[m*PRIO_W +: PRIO_W] = 8'h10;
    exp_q.push_back(note_t'{SPI_BASE_ID + ID_W'(m), 1'b1});
    exp_q.push_back(note_t'{SPI_BASE_ID + ID_W'(k), 1'b1});
    irq[k] = 1'b1;
    wait_for(1, k, n);
    irq[m] = 1'b1;
    highs = 0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      if (fiq_n !== 1'b0) highs++;
    end
    check(16'(highs), 16'h0, "fast line glitch");
    check(16'(ack_id), 16'(SPI_BASE_ID + ID_W'(m)), "replaced id");
    wait_for(2, m, n);
    tick(5);
    irq[m] = 1'b0;
    wait_for(3, m, n);
    wait_for(1, k, n);
    check(16'(n <= PH_LAT_MAX_CYC + 6), 16'h1, "next forwarded");
    wait_for(2, k, n);
    tick(5);
    irq[k] = 1'b0;
    wait_for(3, k, n);
    $display("test replacement done");
    ack_gap = 8'h02;
    k = $unsigned($random(seed)) % NUM_SPI;
    serve(k, 1'b1, 1'b1, 1'b1);
    lv_id = 10'($unsigned($random(seed)) % 32);
    lp_id = SPI_BASE_ID + ID_W'(k);
    lw = 1'b1;
    tick(1);
    lw = 1'b0;
    tick(2);
    check(16'(vfiq_n), 16'h0, "virtual asserted");
    check(16'(vack_id), 16'(lv_id), "virtual id");
    check(16'(full), 16'h1, "entry full");
    tick(12);
    check(16'(vfiq_n), 16'h0, "virtual held");
    vack = 1'b1;
    tick(1);
    vack = 1'b0;
    tick(2);
    check(16'(vfiq_n), 16'h1, "virtual dropped");
    veoi_id = lv_id;
    veoi = 1'b1;
    tick(1);
    veoi = 1'b0;
    veoi_id = ~lv_id;
    tick(3);
    check(16'(act[k]), 16'h0, "linked deactivated");
    check(16'(full), 16'h0, "entry freed");
    $display("test virtual done");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
